// file: scp_pkg.sv
// constants and types of the sensor configuration port and readout sequencer
package scp_pkg;
   // -----------------------------------------------------------------
   // serial frame layout
   // -----------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int HDR_BITS = 8;
   localparam int FRAME_BITS = 16;
   localparam logic CMD_WRITE = 1'b1;
   localparam int CLK_RATIO_MIN = 30;

   // -----------------------------------------------------------------
   // working registers: index, address = CFG_BASE + index
   // -----------------------------------------------------------------
   localparam int NUM_CFG = 11;
   localparam logic [6:0] CFG_BASE = 7'h10;
   localparam int IX_MODE_A = 0;
   localparam int IX_FOT_LO = 1;
   localparam int IX_FOT_HI = 2;
   localparam int IX_ROT = 3;
   localparam int IX_XKER = 4;
   localparam int IX_YLN_LO = 5;
   localparam int IX_YLN_HI = 6;
   localparam int IX_TINT_LO = 7;
   localparam int IX_TINT_HI = 8;
   localparam int IX_TDS = 9;
   localparam int IX_TTS = 10;
   localparam logic [7:0] CFG_RST [NUM_CFG] = '{
      8'h02, 8'h3B, 8'h01, 8'h09, 8'h36, 8'h00, 8'h04, 8'h00, 8'h05, 8'h10, 8'h04};

   // -----------------------------------------------------------------
   // sequencer_mode_reg_a bit positions
   // -----------------------------------------------------------------
   localparam int MODE_EN_BIT = 0;
   localparam int MODE_MASTER_BIT = 1;
   localparam int MODE_TRIG_BIT = 2;
   localparam int MODE_SUB_BIT = 3;
   localparam int MODE_DUAL_BIT = 5;
   localparam int MODE_TRIPLE_BIT = 6;

   // -----------------------------------------------------------------
   // readout geometry
   // -----------------------------------------------------------------
   localparam int KERNEL_PIXELS = 24;
   localparam int PIXELS_PER_EDGE = 12;
   localparam int KERNEL_CYCLES = 2;
   localparam int FULL_KERNELS = 54;
   localparam int NUM_CHANNELS = 13;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_FOT = 4'b0010,
      ST_ROT = 4'b0100,
      ST_PIX = 4'b1000
   } scp_seq_state_e;
endpackage

// file: scp_frame_if.sv
// carrier between the serial link logic and the sensor core
`timescale 1ns/10ps
interface scp_frame_if;
   logic frame_full;
   logic [15:0] frame_word;
   logic mem_we;
   logic [6:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic mem_re;
   logic [6:0] mem_raddr;
   logic [7:0] mem_rdata;
   modport link (output frame_full, frame_word, mem_we, mem_waddr, mem_wdata,
                 mem_re, mem_raddr, input mem_rdata);
   modport core (input frame_full, frame_word, mem_we, mem_waddr, mem_wdata,
                 mem_re, mem_raddr, output mem_rdata);
endinterface

// file: scp_reg_mirror.sv
// readback copy of the register space, written and read on the serial clock
`timescale 1ns/10ps
module scp_reg_mirror #(
   parameter int DEPTH = 128,
   parameter int WIDTH = 8
) (
   // clock
   input wire logic clk,
   // write port
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read port, data registered
   input wire logic re,
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   if (DEPTH != (1 << $clog2(DEPTH)) || WIDTH < 1) begin : g_chk
      $error("scp_reg_mirror: depth must be a power of two");
   end

   // storage has no reset: an entry is undefined until first written
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (re) begin
         rdata <= mem_q[raddr];
      end
   end
endmodule

// file: scp_spi_link.sv
// serial port shifter running on the serial clock
`timescale 1ns/10ps
module scp_spi_link
   import scp_pkg::*;
(
   // serial pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_din,
   output logic spi_dout,
   output logic spi_dout_oe_n,
   // core side
   scp_frame_if.link bus
);
   logic [4:0] cnt_q;
   logic [14:0] shift_q;
   logic rd_q;
   logic [6:0] osh_q;
   logic full_q;
   logic [15:0] word_q;
   wire sel = !spi_cs_n;
   wire at_hdr = (cnt_q == 5'(HDR_BITS - 1));
   wire at_last = (cnt_q == 5'(FRAME_BITS - 1));

   // -----------------------------------------------------------------
   // rising edge: sample input, count bits
   // -----------------------------------------------------------------
   // chip select high holds the counter in reset, so traffic is ignored
   always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         cnt_q <= 5'h00;
         rd_q <= 1'b0;
      end else begin
         if (cnt_q != 5'(FRAME_BITS)) begin
            cnt_q <= cnt_q + 5'h01;
         end
         if (at_hdr) begin
            rd_q <= (shift_q[6] != CMD_WRITE);
         end
      end
   end

   // msb first; bits after a read header fall off unused
   always_ff @(posedge spi_sclk) begin
      if (sel && cnt_q < 5'(FRAME_BITS)) begin
         shift_q <= {shift_q[13:0], spi_din};
      end
   end

   // word stays still once select rises; the core reads it after that
   always_ff @(posedge spi_sclk) begin
      if (sel && cnt_q == 5'h00) begin
         full_q <= 1'b0;
      end else if (sel && at_last) begin
         full_q <= 1'b1;
         word_q <= {shift_q, spi_din};
      end
   end

   // mirror write at the last bit, mirror read at the last address bit
   assign bus.mem_we = sel && at_last && shift_q[14] == CMD_WRITE;
   assign bus.mem_waddr = shift_q[13:7];
   assign bus.mem_wdata = {shift_q[6:0], spi_din};
   assign bus.mem_re = sel && at_hdr && shift_q[6] != CMD_WRITE;
   assign bus.mem_raddr = {shift_q[5:0], spi_din};
   assign bus.frame_full = full_q;
   assign bus.frame_word = word_q;

   // -----------------------------------------------------------------
   // falling edge: drive read data
   // -----------------------------------------------------------------
   // output released whenever select is high or no read answer is due
   always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         spi_dout_oe_n <= 1'b1;
         spi_dout <= 1'b0;
         osh_q <= 7'h00;
      end else if (rd_q && cnt_q == 5'(HDR_BITS)) begin
         spi_dout_oe_n <= 1'b0;
         spi_dout <= bus.mem_rdata[7];
         osh_q <= bus.mem_rdata[6:0];
      end else if (rd_q && cnt_q > 5'(HDR_BITS) && cnt_q < 5'(FRAME_BITS)) begin
         spi_dout <= osh_q[6];
         osh_q <= {osh_q[5:0], 1'b0};
      end else begin
         spi_dout_oe_n <= 1'b1;
         spi_dout <= 1'b0;
      end
   end
endmodule

// file: scp_sensor_core.sv
// sensor configuration port and frame readout sequencer, top level
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`timescale 1ns/10ps
module scp_sensor_core
   import scp_pkg::*;
(
   // system clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // sequencer reset pin
   input wire logic seq_rst_n,
   // serial configuration port
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_din,
   output logic spi_dout,
   output logic spi_dout_oe_n,
   // integration pins and monitors, bit 0 first slope
   input wire logic [2:0] int_time,
   output logic [2:0] monitor,
   // output channel state
   output logic [NUM_CHANNELS-1:0] chan_train,
   // readout timing
   output logic fot_active,
   output logic rot_active,
   output logic pix_active,
   output logic pix_edge,
   output logic [5:0] kernel_idx,
   output logic [9:0] line_idx,
   output logic frame_start,
   output logic core_reset,
   output logic core_sample,
   output logic cfg_commit
);
   // -----------------------------------------------------------------
   // link side
   // -----------------------------------------------------------------
   scp_frame_if bus ();

   scp_spi_link u_link (
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_din(spi_din),
      .spi_dout(spi_dout),
      .spi_dout_oe_n(spi_dout_oe_n),
      .bus(bus.link)
   );

   scp_reg_mirror #(.DEPTH(1 << ADDR_W), .WIDTH(DATA_W)) u_mirror (
      .clk(spi_sclk),
      .we(bus.mem_we),
      .waddr(bus.mem_waddr),
      .wdata(bus.mem_wdata),
      .re(bus.mem_re),
      .raddr(bus.mem_raddr),
      .rdata(bus.mem_rdata)
   );

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic rn_s1_q, rn_s2_q;
   logic [2:0] it_s1_q, it_s2_q, it_s3_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         rn_s1_q <= 1'b0;
         rn_s2_q <= 1'b0;
         it_s1_q <= 3'h0;
         it_s2_q <= 3'h0;
         it_s3_q <= 3'h0;
      end else begin
         cs_s1_q <= spi_cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         rn_s1_q <= seq_rst_n;
         rn_s2_q <= rn_s1_q;
         it_s1_q <= int_time;
         it_s2_q <= it_s1_q;
         it_s3_q <= it_s2_q;
      end
   end

   // the frame word is static once select has risen, so it is read only then
   wire cs_rise = cs_s2_q && !cs_s3_q;
   wire commit = cs_rise && bus.frame_full && bus.frame_word[15] == CMD_WRITE;
   wire [6:0] wr_addr = bus.frame_word[14:8];
   wire [7:0] wr_data = bus.frame_word[7:0];
   wire seq_rst = sys_rst || !rn_s2_q;
   wire int1_rise = it_s2_q[0] && !it_s3_q[0];
   wire int1_fall = !it_s2_q[0] && it_s3_q[0];

   // -----------------------------------------------------------------
   // working registers
   // -----------------------------------------------------------------
   logic [7:0] cfg_q [NUM_CFG];

   // configuration survives a sequencer reset, only the system reset clears it
   for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
      wire hit = commit && (wr_addr == 7'(CFG_BASE + i));
      always_ff @(posedge sys_clk) begin
         if (sys_rst) begin
            cfg_q[i] <= CFG_RST[i];
         end else if (hit) begin
            cfg_q[i] <= wr_data;
         end
      end
   end

   wire seq_en = cfg_q[IX_MODE_A][MODE_EN_BIT];
   wire master = cfg_q[IX_MODE_A][MODE_MASTER_BIT];
   wire trig = cfg_q[IX_MODE_A][MODE_TRIG_BIT];
   wire subsmp = cfg_q[IX_MODE_A][MODE_SUB_BIT];
   wire dual = cfg_q[IX_MODE_A][MODE_DUAL_BIT];
   wire triple = cfg_q[IX_MODE_A][MODE_TRIPLE_BIT];
   wire [15:0] fot_len = {cfg_q[IX_FOT_HI], cfg_q[IX_FOT_LO]};
   wire [7:0] rot_len = cfg_q[IX_ROT];
   wire [5:0] x_kernels = cfg_q[IX_XKER][5:0];
   wire [9:0] y_lines = {cfg_q[IX_YLN_HI][1:0], cfg_q[IX_YLN_LO]};
   wire [15:0] tint = {cfg_q[IX_TINT_HI], cfg_q[IX_TINT_LO]};
   wire [7:0] tds = cfg_q[IX_TDS];
   wire [7:0] tts = cfg_q[IX_TTS];

   // -----------------------------------------------------------------
   // integration control
   // -----------------------------------------------------------------
   logic ig_q;
   logic [15:0] ig_cnt_q;
   logic pend_q;
   logic take;

   // master pipelined restarts at once; triggered waits for a pin edge
   wire ig_start_m = seq_en && !ig_q && (!trig || int1_rise);
   wire ig_end_m = ig_q && ig_cnt_q == 16'h0000;
   wire ig_start = master ? ig_start_m : (seq_en && int1_rise);
   wire ig_end = master ? ig_end_m : (ig_q && int1_fall);

   always_ff @(posedge sys_clk) begin
      if (seq_rst) begin
         ig_q <= 1'b0;
         ig_cnt_q <= 16'h0000;
      end else if (ig_start) begin
         ig_q <= 1'b1;
         ig_cnt_q <= tint;
      end else if (ig_end) begin
         ig_q <= 1'b0;
      end else if (ig_q && ig_cnt_q != 16'h0000) begin
         ig_cnt_q <= ig_cnt_q - 16'h0001;
      end
   end

   // a sample arriving while the readout takes the previous one is kept
   always_ff @(posedge sys_clk) begin
      if (seq_rst) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= ig_end || (pend_q && !take);
      end
   end

   // monitors: on-chip slopes count the tail of the integration window
   wire mon1_d = ig_q;
   wire mon2_d = dual && (master ? (ig_q && ig_cnt_q < {8'h00, tds}) : it_s2_q[1]);
   wire mon3_d = triple && (master ? (ig_q && ig_cnt_q < {8'h00, tts}) : it_s2_q[2]);

   always_ff @(posedge sys_clk) begin
      if (seq_rst) begin
         monitor <= 3'h0;
         core_reset <= 1'b0;
         core_sample <= 1'b0;
      end else begin
         monitor <= {mon3_d, mon2_d, mon1_d};
         core_reset <= ig_start;
         core_sample <= ig_end;
      end
   end

   // -----------------------------------------------------------------
   // readout sequencer
   // -----------------------------------------------------------------
   scp_seq_state_e st_q, st_d;
   logic [15:0] tm_q, tm_d;
   logic [5:0] kern_q, kern_d;
   logic [9:0] line_q, line_d;
   logic half_q, half_d;
   logic fs_d;

   // zero overhead lengths fall back to a single cycle, a zero kernel count to one kernel
   wire [15:0] fot_load = (fot_len == 16'h0000) ? 16'h0000 : fot_len - 16'h0001;
   wire [15:0] rot_load = (rot_len == 8'h00) ? 16'h0000 : {8'h00, rot_len - 8'h01};
   wire [5:0] x_last = (x_kernels == 6'h00) ? 6'h00 : x_kernels - 6'h01;
   wire [9:0] line_step = subsmp ? 10'h002 : 10'h001;
   wire [9:0] next_line = line_q + line_step;
   wire last_line = next_line >= y_lines;
   wire tm_zero = tm_q == 16'h0000;

   always_comb begin
      st_d = st_q;
      tm_d = tm_q;
      kern_d = kern_q;
      line_d = line_q;
      half_d = 1'b0;
      take = 1'b0;
      fs_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (seq_en && pend_q) begin
               st_d = ST_FOT;
               tm_d = fot_load;
               line_d = 10'h000;
               take = 1'b1;
               fs_d = 1'b1;
            end
         end
         ST_FOT: begin
            tm_d = tm_q - 16'h0001;
            if (tm_zero) begin
               st_d = ST_ROT;
               tm_d = rot_load;
               line_d = 10'h000;
            end
         end
         ST_ROT: begin
            tm_d = tm_q - 16'h0001;
            if (tm_zero) begin
               st_d = ST_PIX;
               kern_d = 6'h00;
            end
         end
         ST_PIX: begin
            half_d = !half_q;
            if (half_q && kern_q == x_last) begin
               st_d = last_line ? ST_IDLE : ST_ROT;
               tm_d = rot_load;
               line_d = last_line ? line_q : next_line;
            end else if (half_q) begin
               kern_d = kern_q + 6'h01;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (seq_rst) begin
         st_q <= ST_IDLE;
         tm_q <= 16'h0000;
         kern_q <= 6'h00;
         line_q <= 10'h000;
         half_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tm_q <= tm_d;
         kern_q <= kern_d;
         line_q <= line_d;
         half_q <= half_d;
      end
   end

   // -----------------------------------------------------------------
   // registered status outputs
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (seq_rst) begin
         chan_train <= {NUM_CHANNELS{1'b1}};
         frame_start <= 1'b0;
      end else begin
         chan_train <= {NUM_CHANNELS{!seq_en}};
         frame_start <= fs_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_commit <= 1'b0;
      end else begin
         cfg_commit <= commit;
      end
   end

   // one-hot state bits are flops, so these outputs need no decode
   assign fot_active = st_q[1];
   assign rot_active = st_q[2];
   assign pix_active = st_q[3];
   assign pix_edge = half_q;
   assign kernel_idx = kern_q;
   assign line_idx = line_q;
endmodule

// file: scp_spi_host.sv
// serial host model that frames register accesses toward the sensor core
`timescale 1ns/10ps
module scp_spi_host
   import scp_pkg::*;
(
   // serial pins toward the device
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_din,
   input wire logic spi_dout,
   input wire logic spi_dout_oe_n,
   // set once the output enable misbehaved in any frame
   output logic oe_bad
);
   // select starts low and rises once: a select rising edge is the link's only reset
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b0;
      spi_din = 1'b0;
      oe_bad = 1'b0;
      #1;
      spi_cs_n = 1'b1;
   end

   // one frame, msb first; clock stands high between frames, 30 ns period
   task automatic xfer(input logic [15:0] w, input int nb, output logic [7:0] rd);
      logic exp_oe;
      rd = 8'h00;
      // 2.5 ns lead keeps every link edge off the system clock edges
      #2.5;
      spi_cs_n = 1'b0;
      #7;
      for (int i = 0; i < nb; i++) begin
         spi_sclk = 1'b0;
         spi_din = w[15-i];
         #15;
         spi_sclk = 1'b1;
         exp_oe = (w[15] != CMD_WRITE && i >= 8) ? 1'b0 : 1'b1;
         if (spi_dout_oe_n !== exp_oe) begin
            oe_bad = 1'b1;
         end
         if (i >= 8) begin
            rd = {rd[6:0], spi_dout};
         end
         #15;
      end
      #7;
      spi_cs_n = 1'b1;
      // released line shows the inverse so a stale bit is never trusted
      spi_din = ~spi_din;
      #79.5;
   endtask
endmodule

// file: scp_sensor_core_properties.sv
// concurrent checks on the sensor core ports
`timescale 1ns/10ps
module scp_sensor_core_properties
   import scp_pkg::*;
(
   // clock and resets
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic seq_rst_n,
   // serial port
   input wire logic spi_cs_n,
   input wire logic spi_dout_oe_n,
   // readout
   input wire logic [NUM_CHANNELS-1:0] chan_train,
   input wire logic fot_active,
   input wire logic rot_active,
   input wire logic pix_active,
   input wire logic pix_edge,
   input wire logic [5:0] kernel_idx,
   input wire logic [9:0] line_idx,
   input wire logic frame_start,
   input wire logic cfg_commit
);
   // sequencer reset pin also masks, since its synchroniser lags the pin
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst || !seq_rst_n);

   // -----------------------------------------------------------------
   // multi-step sequences
   // -----------------------------------------------------------------
   sequence kernel_seq;
      pix_active && !pix_edge ##1 pix_active && pix_edge;
   endsequence
   sequence frame_open_seq;
      fot_active && line_idx == 10'h000 ##1 !frame_start;
   endsequence

   a_oe_deselect: assert property (spi_cs_n |-> spi_dout_oe_n)
      else $error("serial output enabled while deselected");
   a_commit_late: assert property (cfg_commit |-> spi_cs_n && $past(spi_cs_n, 3))
      else $error("commit without chip select release");
   a_commit_single: assert property (cfg_commit |=> !cfg_commit)
      else $error("commit pulse longer than one cycle");
   a_frame_open: assert property (frame_start |-> frame_open_seq)
      else $error("frame did not open with frame overhead");
   a_train_off: assert property (frame_start |-> chan_train == '0)
      else $error("training pattern during readout");
   a_one_phase: assert property ($onehot0({fot_active, rot_active, pix_active}))
      else $error("overlapping readout phases");
   a_fot_to_rot: assert property ($fell(fot_active) |-> rot_active && line_idx == 10'h000)
      else $error("frame overhead not followed by row overhead");
   a_kernel_pair: assert property (pix_active && !pix_edge |-> kernel_seq)
      else $error("kernel not two cycles");
   a_rot_to_pix: assert property ($rose(pix_active) |-> $past(rot_active) && kernel_idx == 6'h00)
      else $error("line did not start at kernel zero after row overhead");
   a_seq_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !seq_rst_n [*5] |-> !(fot_active || rot_active || pix_active))
      else $error("sequencer active while held in reset");
endmodule

bind scp_sensor_core scp_sensor_core_properties u_props (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .seq_rst_n(seq_rst_n), .spi_cs_n(spi_cs_n),
   .spi_dout_oe_n(spi_dout_oe_n), .chan_train(chan_train), .fot_active(fot_active),
   .rot_active(rot_active), .pix_active(pix_active), .pix_edge(pix_edge),
   .kernel_idx(kernel_idx), .line_idx(line_idx), .frame_start(frame_start),
   .cfg_commit(cfg_commit));

// file: scp_sensor_core_bench.sv
// self-checking bench of the sensor core driven by the serial host model
`timescale 1ns/10ps
module scp_sensor_core_bench
   import scp_pkg::*;
;
   logic sys_clk, sys_rst, seq_rst_n, sclk, cs_n, din, dout, oe_n, oe_bad;
   logic [2:0] int_time, monitor;
   logic [NUM_CHANNELS-1:0] chan_train;
   logic fot_active, rot_active, pix_active, pix_edge, frame_start;
   logic core_reset, core_sample, cfg_commit;
   logic [5:0] kernel_idx;
   logic [9:0] line_idx;
   logic [7:0] rd;
   int error_cnt = 0;
   int compares = 0;
   int commits = 0;
   int samples = 0;
   int smp0 = 0;
   // rows: address, byte written, byte expected back; 0x55 steers nothing
   logic [7:0] rows [9][3] = '{'{8'h11, 8'h04, 8'h04}, '{8'h12, 8'h00, 8'h00},
      '{8'h13, 8'h02, 8'h02}, '{8'h14, 8'h03, 8'h03}, '{8'h15, 8'h02, 8'h02},
      '{8'h16, 8'h00, 8'h00}, '{8'h17, 8'h10, 8'h10}, '{8'h18, 8'h00, 8'h00},
      '{8'h55, 8'hA5, 8'hA5}};

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   scp_sensor_core DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .seq_rst_n(seq_rst_n),
      .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_din(din), .spi_dout(dout),
      .spi_dout_oe_n(oe_n), .int_time(int_time), .monitor(monitor),
      .chan_train(chan_train), .fot_active(fot_active), .rot_active(rot_active),
      .pix_active(pix_active), .pix_edge(pix_edge), .kernel_idx(kernel_idx),
      .line_idx(line_idx), .frame_start(frame_start), .core_reset(core_reset),
      .core_sample(core_sample), .cfg_commit(cfg_commit));
   scp_spi_host host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_din(din), .spi_dout(dout),
      .spi_dout_oe_n(oe_n), .oe_bad(oe_bad));

   // commit pulses are counted, a stretched pulse would count twice
   always @(posedge sys_clk) begin
      if (cfg_commit === 1'b1) begin
         commits++;
      end
      if (core_sample === 1'b1) begin
         samples++;
      end
   end

   task automatic end_sim;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d, input int nb);
      host.xfer({CMD_WRITE, a, d}, nb, rd);
   endtask

   // read with ones after the address, which the device must ignore
   task automatic rdback(input logic [6:0] a, input logic [7:0] exp);
      host.xfer({~CMD_WRITE, a, 8'hFF}, 16, rd);
      chk("readback", {8'h00, exp}, {8'h00, rd});
      chk("output enable", 16'h0, {15'h0, oe_bad});
   endtask

   // counts phases over one frame from its start pulse
   task automatic measure(input int fot, input int rot, input int xk, input int nl,
         input int stp);
      int nf, nr, np, ml, mk, i;
      nf = 0;
      nr = 0;
      np = 0;
      ml = 0;
      mk = 0;
      i = 0;
      while (frame_start !== 1'b1 && i < 2000) begin
         @(posedge sys_clk);
         #1;
         i++;
      end
      chk("frame start", 16'h1, {15'h0, frame_start});
      repeat (fot + nl * (rot + 2 * xk)) begin
         nf += (fot_active === 1'b1);
         nr += (rot_active === 1'b1);
         np += (pix_active === 1'b1);
         if (pix_active === 1'b1 && line_idx > ml) ml = line_idx;
         if (pix_active === 1'b1 && kernel_idx > mk) mk = kernel_idx;
         @(posedge sys_clk);
         #1;
      end
      chk("frame overhead", 16'(fot), 16'(nf));
      chk("row overhead", 16'(nl * rot), 16'(nr));
      chk("pixel cycles", 16'(nl * 2 * xk), 16'(np));
      chk("last kernel", 16'(xk - 1), 16'(mk));
      chk("last line", 16'((nl - 1) * stp), 16'(ml));
   endtask

   // generous bound: whole run needs well under a tenth of it
   initial begin
      #300us;
      error_cnt++;
      $display("[ERR] watchdog expected finish seen hang");
      end_sim();
   end

   initial begin
      sys_rst = 1'b1;
      seq_rst_n = 1'b1;
      int_time = 3'h0;
      repeat (10) @(posedge sys_clk);
      #1;
      chk("train in reset", 16'h1FFF, 16'(chan_train));
      chk("oe in reset", 16'h1, {15'h0, oe_n});
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      // timing upload while disabled: fot 4, rot 2, 3 kernels, 2 lines, tint 0x10
      foreach (rows[i]) begin
         wr(rows[i][0][6:0], rows[i][1], 16);
         rdback(rows[i][0][6:0], rows[i][2]);
      end
      chk("commit count", 16'd9, 16'(commits));
      // cut write frame is dropped
      wr(7'h13, 8'h7E, 12);
      chk("short write", 16'd9, 16'(commits));
      rdback(7'h13, 8'h02);
      // master pipelined readout
      wr(7'h10, 8'h03, 16);
      measure(4, 2, 3, 2, 1);
      chk("monitor seen", 16'h1, 16'h1 & 16'(monitor | {2'h0, core_reset}));
      wr(7'h10, 8'h02, 16);
      repeat (30) @(posedge sys_clk);
      #1;
      chk("train disabled", 16'h1FFF, 16'(chan_train));
      // subsampled lines step by two
      wr(7'h15, 8'h04, 16);
      wr(7'h10, 8'h0B, 16);
      measure(4, 2, 3, 2, 2);
      @(posedge sys_clk);
      seq_rst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      chk("held in reset", 16'h0, {13'h0, fot_active, rot_active, pix_active});
      @(posedge sys_clk);
      seq_rst_n <= 1'b1;
      // slave mode, integration from the pin
      wr(7'h10, 8'h00, 16);
      wr(7'h10, 8'h01, 16);
      @(posedge sys_clk);
      int_time <= 3'h1;
      repeat (8) @(posedge sys_clk);
      #1;
      chk("slave monitor", 16'h1, {15'h0, monitor[0]});
      @(posedge sys_clk);
      smp0 = samples;
      int_time <= 3'h0;
      measure(4, 2, 3, 4, 1);
      chk("slave release", 16'h0, {15'h0, monitor[0]});
      chk("sample pulses", 16'h1, 16'(samples - smp0));
      end_sim();
   end
endmodule
